// >>> design/ai_pacer_pkg.sv
// Shared constants, modes and carriers for the analog input pacer and trigger block
package ai_pacer_pkg;

  // Clock rates in Hz; the 100 MHz time base is made from the 125 MHz clock
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned TIMEBASE_HZ = 100_000_000;
  localparam int unsigned RATE_UNIT   = 1_000_000;
  localparam int unsigned TB_STEP     = TIMEBASE_HZ / RATE_UNIT;
  localparam int unsigned TB_WRAP     = CLK_HZ / RATE_UNIT;
  localparam int          TB_ACC_W    = 8;

  localparam int DIV_W      = 32;
  localparam int CODE_W     = 16;
  localparam int CHAN_W     = 4;
  localparam int ITER_W     = 16;
  localparam int FIFO_DEPTH = 4;

  // Values after reset
  localparam logic [DIV_W-1:0]    DIV_RST  = 32'h00000000;
  localparam logic [ITER_W-1:0]   ITER_ONE = 16'h0001;
  localparam logic [CHAN_W-1:0]   CHAN_RST = 4'h0;
  localparam logic [TB_ACC_W-1:0] ACC_RST  = 8'h00;

  typedef enum logic [1:0] {LAUNCH_INTERNAL, LAUNCH_EXTERNAL, LAUNCH_FROM_SAMPLE} launch_src_e;
  typedef enum logic {SAMPLE_INTERNAL, SAMPLE_EXTERNAL} sample_src_e;
  typedef enum logic [2:0] {TRIG_NONE, TRIG_START, TRIG_DELAY_START, TRIG_DELAY_STOP, TRIG_STOP} trig_mode_e;
  typedef enum logic {TRIG_FROM_TTL, TRIG_FROM_ANALOG} trig_src_e;

  typedef struct packed {
    launch_src_e         launch_src;
    sample_src_e         sample_src;
    logic [DIV_W-1:0]    launch_div;
    logic [DIV_W-1:0]    sample_div;
    logic [DIV_W-1:0]    trig_delay;
    logic [ITER_W-1:0]   iter_count;
    logic [CHAN_W-1:0]   start_chan;
    logic [CHAN_W-1:0]   stop_chan;
    trig_mode_e          trig_mode;
    trig_src_e           trig_src;
    logic                trig_falling;
    logic                pause;
    logic [CODE_W-1:0]   threshold;
  } cfg_s;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [CODE_W-1:0] code;
  } sample_s;

endpackage : ai_pacer_pkg

// >>> design/ai_pacer_trigger_control.sv
// Pacer, trigger, acquisition window and result buffer for the analog input converter
`timescale 1ns/1ps

module rate_divider (
  input  wire logic                           clk,     // System clock
  input  wire logic                           rst_b,   // Synchronous reset, active low
  input  wire logic                           enable,  // Divider runs while high
  input  wire logic                           tb_tick, // One 100 MHz time base tick
  input  wire logic [ai_pacer_pkg::DIV_W-1:0] div,     // Divide ratio, 0 acts as 1
  output logic                                tick     // One-cycle output pulse
);
  import ai_pacer_pkg::*;

  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] last;

  assign last = (div == DIV_RST) ? DIV_RST : div - 32'h00000001;

  always_ff @(posedge clk) begin
    if (!rst_b || !enable) begin
      cnt  <= DIV_RST;
      tick <= 1'b0;
    end else if (tb_tick && cnt >= last) begin
      cnt  <= DIV_RST;
      tick <= 1'b1;
    end else begin
      cnt  <= tb_tick ? cnt + 32'h00000001 : cnt;
      tick <= 1'b0;
    end
  end
endmodule : rate_divider

module sync_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,       // System clock
  input  wire logic         rst_b,     // Synchronous reset, active low
  input  wire logic         in_valid,  // Write request
  output logic              in_ready,  // Space for one more word
  input  wire logic [W-1:0] in_data,   // Word written
  output logic              out_valid, // A word is waiting
  input  wire logic         out_ready, // Reader takes the word
  output logic [W-1:0]      out_data   // Oldest word
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic          push;
  logic          pop;

  assign in_ready  = count < CW'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= push ? PW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= pop ? PW'(rd_ptr + 1'b1) : rd_ptr;
      count  <= CW'(count + CW'(push) - CW'(pop));
    end
  end
endmodule : sync_fifo

module ai_pacer_trigger_control (
  input  wire logic                            clk,                  // 125 MHz clock
  input  wire logic                            rst_b,                // Synchronous reset, active low
  input  wire ai_pacer_pkg::cfg_s              cfg,                  // Software configuration
  input  wire logic                            run,                  // Operation running while high
  input  wire logic                            ext_window_launch,    // External launch clock input
  input  wire logic                            ext_per_sample_clock, // External per-sample clock input
  input  wire logic                            ext_ttl_trigger,      // External digital trigger input
  input  wire logic [ai_pacer_pkg::CODE_W-1:0] analog_trigger_inputs,// Monitored analog level code
  input  wire logic                            adc_done,             // Converter result strobe
  input  wire logic [ai_pacer_pkg::CODE_W-1:0] adc_code,             // Converter result code
  input  wire logic                            out_ready,            // Host side takes a result
  output logic                                 sample_start,         // Conversion start pulse
  output logic [ai_pacer_pkg::CHAN_W-1:0]      mux_chan,             // Channel on the multiplexer
  output logic                                 window_open,          // Acquisition window open
  output logic                                 acquiring,            // Trigger logic admits launches
  output logic [ai_pacer_pkg::DIV_W-1:0]       launch_count,         // Received launch edges
  output logic [ai_pacer_pkg::ITER_W-1:0]      iter_left,            // Iterations left in window
  output logic                                 lost_clock,           // Sticky: a clock was gated off
  output logic                                 out_valid,            // Result waiting
  output ai_pacer_pkg::sample_s                out_data              // Channel and code
);
  import ai_pacer_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_DELAY, ST_ACQ, ST_POST, ST_DONE} acq_state_e;

  acq_state_e        state;
  logic [DIV_W-1:0]  dly_cnt;
  logic [TB_ACC_W-1:0] tb_acc;
  logic              tb_tick;
  logic              int_launch;
  logic              int_sample;
  logic              launch_q;
  logic              sample_q;
  logic              trig_q;
  logic              run_q;
  logic              run_rise;
  logic              ext_launch_rise;
  logic              ext_sample_rise;
  logic              sample_evt;
  logic              launch_evt;
  logic              trig_level;
  logic              trig_evt;
  logic              admit;
  logic              launch_go;
  logic              sample_go;
  logic              busy;
  logic [CHAN_W-1:0] chan_ptr;
  logic [ITER_W-1:0] iters_eff;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  sample_s           fifo_out_data;
  sample_s           fifo_in_data;

  // 100 ticks in every 125 clocks gives an average 100 MHz time base
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tb_acc  <= ACC_RST;
      tb_tick <= 1'b0;
    end else if (tb_acc + TB_ACC_W'(TB_STEP) >= TB_ACC_W'(TB_WRAP)) begin
      tb_acc  <= TB_ACC_W'(tb_acc + TB_ACC_W'(TB_STEP) - TB_ACC_W'(TB_WRAP));
      tb_tick <= 1'b1;
    end else begin
      tb_acc  <= TB_ACC_W'(tb_acc + TB_ACC_W'(TB_STEP));
      tb_tick <= 1'b0;
    end
  end

  rate_divider u_launch_div (
    .clk     (clk),
    .rst_b   (rst_b),
    .enable  (run),
    .tb_tick (tb_tick),
    .div     (cfg.launch_div),
    .tick    (int_launch)
  );

  rate_divider u_sample_div (
    .clk     (clk),
    .rst_b   (rst_b),
    .enable  (run),
    .tb_tick (tb_tick),
    .div     (cfg.sample_div),
    .tick    (int_sample)
  );

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      launch_q <= 1'b0;
      sample_q <= 1'b0;
      trig_q   <= 1'b0;
      run_q    <= 1'b0;
    end else begin
      launch_q <= ext_window_launch;
      sample_q <= ext_per_sample_clock;
      trig_q   <= trig_level;
      run_q    <= run;
    end
  end

  assign run_rise        = run && !run_q;
  assign ext_launch_rise = ext_window_launch && !launch_q;
  assign ext_sample_rise = ext_per_sample_clock && !sample_q;
  assign sample_evt      = (cfg.sample_src == SAMPLE_EXTERNAL) ? ext_sample_rise : int_sample;

  // External launch input is not looked at in single-source mode
  always_comb begin
    unique case (cfg.launch_src)
      LAUNCH_INTERNAL:    launch_evt = int_launch;
      LAUNCH_EXTERNAL:    launch_evt = ext_launch_rise;
      LAUNCH_FROM_SAMPLE: launch_evt = sample_evt;
      default:            launch_evt = 1'b0;
    endcase
  end

  // Offset-binary codes compare correctly as unsigned numbers
  assign trig_level = (cfg.trig_src == TRIG_FROM_ANALOG) ?
                      (analog_trigger_inputs >= cfg.threshold) :
                      ext_ttl_trigger;
  assign trig_evt   = cfg.trig_falling ? (!trig_level && trig_q) : (trig_level && !trig_q);

  assign admit     = (state == ST_ACQ) || (state == ST_POST);
  assign launch_go = run && launch_evt && !cfg.pause && admit && !window_open;
  // One conversion outstanding at most, so a free slot at start is still free at result
  assign sample_go = run && sample_evt && window_open && !busy && fifo_in_ready;
  assign iters_eff = (cfg.iter_count == '0) ? ITER_ONE : cfg.iter_count;

  // Trigger sequencing; DONE holds until run is dropped
  always_ff @(posedge clk) begin
    if (!rst_b || !run) begin
      state   <= ST_IDLE;
      dly_cnt <= DIV_RST;
    end else begin
      unique case (state)
        ST_IDLE: begin
          state <= (cfg.trig_mode == TRIG_START || cfg.trig_mode == TRIG_DELAY_START) ?
                   ST_ARMED : ST_ACQ;
        end
        ST_ARMED: begin
          if (trig_evt) begin
            if (cfg.trig_mode == TRIG_START || cfg.trig_delay == DIV_RST) begin
              state <= ST_ACQ;
            end else begin
              state   <= ST_DELAY;
              dly_cnt <= cfg.trig_delay;
            end
          end
        end
        ST_DELAY: begin
          if (launch_evt && !cfg.pause) begin
            dly_cnt <= dly_cnt - 32'h00000001;
            if (dly_cnt == 32'h00000001) begin
              state <= ST_ACQ;
            end
          end
        end
        ST_ACQ: begin
          if (trig_evt && cfg.trig_mode == TRIG_STOP) begin
            state <= ST_DONE;
          end else if (trig_evt && cfg.trig_mode == TRIG_DELAY_STOP) begin
            if (cfg.trig_delay == DIV_RST) begin
              state <= ST_DONE;
            end else begin
              state   <= ST_POST;
              dly_cnt <= cfg.trig_delay;
            end
          end
        end
        ST_POST: begin
          if (launch_go) begin
            dly_cnt <= dly_cnt - 32'h00000001;
            if (dly_cnt == 32'h00000001) begin
              state <= ST_DONE;
            end
          end
        end
        ST_DONE: state <= ST_DONE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Window and channel sequencing
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      window_open  <= 1'b0;
      chan_ptr     <= CHAN_RST;
      mux_chan     <= CHAN_RST;
      iter_left    <= ITER_ONE;
      sample_start <= 1'b0;
    end else begin
      sample_start <= sample_go;
      if (!run) begin
        window_open <= 1'b0;
        iter_left   <= iters_eff;
      end else if (launch_go) begin
        window_open <= 1'b1;
        chan_ptr    <= cfg.start_chan;
        iter_left   <= iters_eff;
      end else if (sample_go) begin
        mux_chan <= chan_ptr;
        if (chan_ptr == cfg.stop_chan) begin
          chan_ptr <= cfg.start_chan;
          if (iter_left == ITER_ONE) begin
            window_open <= 1'b0;
            iter_left   <= iters_eff;
          end else begin
            iter_left <= iter_left - ITER_ONE;
          end
        end else begin
          chan_ptr <= CHAN_W'(chan_ptr + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy <= 1'b0;
    end else if (sample_go) begin
      busy <= 1'b1;
    end else if (adc_done) begin
      busy <= 1'b0;
    end
  end

  // Counter clears on start; gated-off flag: a new loss beats the clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      launch_count <= DIV_RST;
      lost_clock   <= 1'b0;
      acquiring    <= 1'b0;
    end else begin
      acquiring <= run && admit;
      if (run_rise) begin
        launch_count <= DIV_RST;
      end else if (run && launch_evt) begin
        launch_count <= launch_count + 32'h00000001;
      end
      lost_clock <= (lost_clock && !run_rise) ||
                    (run && sample_evt && !sample_go) ||
                    (run && launch_evt && admit && window_open);
    end
  end

  assign fifo_in_data = '{chan: mux_chan, code: adc_code};

  sync_fifo #(
    .W     ($bits(sample_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (adc_done && busy),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out_data)
  );

  assign out_valid = fifo_out_valid;
  assign out_data  = fifo_out_data;

  chk_start_in_window: assert property (@(posedge clk) disable iff (!rst_b)
    sample_start |-> $past(window_open))
    else $error("conversion started with window closed");

  chk_gate_closed: assert property (@(posedge clk) disable iff (!rst_b)
    (!window_open && sample_evt) |=> !sample_start)
    else $error("sample clock outside window was passed on");

  chk_reload_end: assert property (@(posedge clk) disable iff (!rst_b)
    (run && $fell(window_open) && $past(run)) |-> iter_left == $past(iters_eff))
    else $error("iteration counter not reloaded at window end");

  chk_last_iter: assert property (@(posedge clk) disable iff (!rst_b)
    (sample_go && !launch_go && chan_ptr == cfg.stop_chan && iter_left == ITER_ONE) |=> !window_open)
    else $error("window did not close after last iteration");

  chk_launch_count: assert property (@(posedge clk) disable iff (!rst_b)
    (run && launch_evt && !run_rise) |=> launch_count == $past(launch_count) + 32'h00000001)
    else $error("launch edge not counted");

  chk_block_armed: assert property (@(posedge clk) disable iff (!rst_b)
    (state inside {ST_ARMED, ST_DELAY} && !window_open) |=> !window_open)
    else $error("launch admitted before trigger");

  chk_stop_trig: assert property (@(posedge clk) disable iff (!rst_b)
    (run && state == ST_ACQ && cfg.trig_mode == TRIG_STOP && trig_evt) ##1 run |-> state == ST_DONE)
    else $error("stop trigger did not end acquisition");

  chk_delay_load: assert property (@(posedge clk) disable iff (!rst_b)
    (run && state == ST_ARMED && cfg.trig_mode == TRIG_DELAY_START && trig_evt && cfg.trig_delay != DIV_RST)
    ##1 run |-> (state == ST_DELAY && dly_cnt == $past(cfg.trig_delay)))
    else $error("delay counter not loaded on trigger");

  chk_single_source: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg.launch_src == LAUNCH_FROM_SAMPLE) |-> (launch_evt == sample_evt))
    else $error("sample clock not routed as launch clock");

  chk_full_stall: assert property (@(posedge clk) disable iff (!rst_b)
    !fifo_in_ready |=> !sample_start)
    else $error("conversion started with buffer full");

endmodule : ai_pacer_trigger_control

// >>> test/adc_model.sv
// Behavioural converter that answers each conversion start with one result
`timescale 1ns/1ps
module adc_model (
  input  wire logic                            clk,          // System clock
  input  wire logic                            sample_start, // Conversion start pulse
  input  wire logic [ai_pacer_pkg::CHAN_W-1:0] mux_chan,     // Channel being converted
  input  wire logic [3:0]                      latency,      // Cycles from start to result
  output logic                                 adc_done,     // Result strobe
  output logic [ai_pacer_pkg::CODE_W-1:0]      adc_code      // Result code
);
  import ai_pacer_pkg::*;
  logic [3:0]        left;
  logic              busy;
  logic [CHAN_W-1:0] chan;
  initial begin
    busy = 1'b0;
    adc_done = 1'b0;
    adc_code = 16'h0000;
  end
  always @(posedge clk) begin
    adc_done <= 1'b0;
    // Code toggles outside the strobe so a stale value never looks valid
    adc_code <= ~adc_code;
    if (sample_start) begin
      busy <= 1'b1;
      left <= latency;
      chan <= mux_chan;
    end else if (busy) begin
      if (left <= 4'h1) begin
        busy <= 1'b0;
        adc_done <= 1'b1;
        adc_code <= 16'h8000 | {12'h000, chan};
      end else begin
        left <= left - 4'h1;
      end
    end
  end
endmodule : adc_model

// >>> test/ai_pacer_trigger_control_tb_top.sv
// Testbench for the analog input pacer and trigger block
`timescale 1ns/1ps
module ai_pacer_trigger_control_tb_top;
  import ai_pacer_pkg::*;
  logic clk, rst_b, run, ext_window_launch, ext_per_sample_clock, ext_ttl_trigger;
  logic adc_done, out_ready, sample_start, window_open, acquiring, lost_clock, out_valid;
  logic [CODE_W-1:0] analog_trigger_inputs, adc_code;
  logic [CHAN_W-1:0] mux_chan;
  logic [DIV_W-1:0]  launch_count, lc;
  logic [ITER_W-1:0] iter_left;
  logic [3:0]        adc_lat;
  cfg_s              cfg;
  sample_s           out_data;
  sample_s           got[$];
  int                num_errors, tests_run, cyc, starts;
  localparam int     EXT_GAP = 250;

  ai_pacer_trigger_control i_ai_pacer_trigger_control (.clk(clk), .rst_b(rst_b), .cfg(cfg), .run(run),
    .ext_window_launch(ext_window_launch), .ext_per_sample_clock(ext_per_sample_clock),
    .ext_ttl_trigger(ext_ttl_trigger), .analog_trigger_inputs(analog_trigger_inputs), .adc_done(adc_done),
    .adc_code(adc_code), .out_ready(out_ready), .sample_start(sample_start), .mux_chan(mux_chan),
    .window_open(window_open), .acquiring(acquiring), .launch_count(launch_count), .iter_left(iter_left),
    .lost_clock(lost_clock), .out_valid(out_valid), .out_data(out_data));
  adc_model i_adc_model (.clk(clk), .sample_start(sample_start), .mux_chan(mux_chan), .latency(adc_lat),
    .adc_done(adc_done), .adc_code(adc_code));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // One rising edge on launch (0), sample (1) or digital trigger (2), then a gap
  task automatic pulse(input int which, input int gap);
    // Pacing edges at least 2 us apart, inside the 500 kHz source limit
    if (which < 2) step(EXT_GAP);
    if (which == 0) ext_window_launch = 1'b1;
    else if (which == 1) ext_per_sample_clock = 1'b1;
    else ext_ttl_trigger = 1'b1;
    step(1);
    ext_window_launch = 1'b0;
    ext_per_sample_clock = 1'b0;
    ext_ttl_trigger = 1'b0;
    step(gap);
  endtask : pulse

  task automatic arm(input trig_mode_e m, input trig_src_e s, input logic fall);
    run = 1'b0;
    step(2);
    cfg.trig_mode = m;
    cfg.trig_src = s;
    cfg.trig_falling = fall;
    run = 1'b1;
    step(3);
  endtask : arm

  always @(posedge clk) begin
    cyc++;
    if (sample_start) starts++;
    if (out_valid && out_ready) got.push_back(out_data);
    if (cyc == 40000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    rst_b = 1'b0;
    cfg = '0;
    run = 1'b0;
    ext_window_launch = 1'b0;
    ext_per_sample_clock = 1'b0;
    ext_ttl_trigger = 1'b0;
    analog_trigger_inputs = 16'h7FFF;
    out_ready = 1'b1;
    adc_lat = 4'h2;
    step(12);
    rst_b = 1'b1;
    check("iter_left_rst", iter_left, 32'h1);
    check("window_rst", window_open, 32'h0);
    cfg.launch_src = LAUNCH_EXTERNAL;
    cfg.sample_src = SAMPLE_EXTERNAL;
    cfg.start_chan = 4'h2;
    cfg.stop_chan = 4'h3;
    cfg.iter_count = 16'h0002;
    cfg.trig_delay = 32'h00000002;
    cfg.threshold = 16'h8000;
    run = 1'b1;
    step(3);
    pulse(1, 6);
    check("starts_closed", starts, 32'h0);
    check("lost_clock", lost_clock, 32'h1);
    pulse(0, 3);
    check("window_open", window_open, 32'h1);
    check("launch_count", launch_count, 32'h1);
    repeat (6) pulse(1, 8);
    check("starts_window", starts, 32'h4);
    check("window_closed", window_open, 32'h0);
    check("iter_reload", iter_left, 32'h2);
    check("results", got.size(), 32'h4);
    foreach (got[i]) check("chan_code", got[i], {4'h2 + i[3:0] % 4'h2, 16'h8002 + i[15:0] % 16'h2});
    // Buffer fills with the reader stalled, slow converter
    starts = 0;
    got.delete();
    adc_lat = 4'h6;
    out_ready = 1'b0;
    cfg.start_chan = 4'h5;
    cfg.stop_chan = 4'h5;
    cfg.iter_count = 16'h0006;
    pulse(0, 3);
    repeat (6) pulse(1, 10);
    check("starts_full", starts, 32'h4);
    check("full_open", window_open, 32'h1);
    out_ready = 1'b1;
    step(8);
    check("drained", got.size(), 32'h4);
    check("empty", out_valid, 32'h0);
    repeat (2) pulse(1, 10);
    check("starts_total", starts, 32'h6);
    check("full_closed", window_open, 32'h0);
    adc_lat = 4'h2;
    cfg.start_chan = 4'h0;
    cfg.stop_chan = 4'h0;
    cfg.iter_count = 16'h0001;
    cfg.launch_src = LAUNCH_FROM_SAMPLE;
    arm(TRIG_NONE, TRIG_FROM_TTL, 1'b0);
    pulse(0, 4);
    check("ext_launch_ignored", launch_count, 32'h0);
    pulse(1, 10);
    check("sample_as_launch", launch_count, 32'h1);
    cfg.launch_src = LAUNCH_EXTERNAL;
    arm(TRIG_START, TRIG_FROM_TTL, 1'b0);
    pulse(0, 4);
    check("start_blocked", window_open, 32'h0);
    pulse(2, 3);
    check("start_acq", acquiring, 32'h1);
    pulse(0, 4);
    check("start_window", window_open, 32'h1);
    pulse(1, 10);
    arm(TRIG_DELAY_START, TRIG_FROM_ANALOG, 1'b0);
    analog_trigger_inputs = 16'h8000;
    step(3);
    repeat (2) pulse(0, 4);
    check("dstart_wait", window_open, 32'h0);
    check("dstart_acq", acquiring, 32'h1);
    pulse(0, 4);
    check("dstart_window", window_open, 32'h1);
    pulse(1, 10);
    ext_ttl_trigger = 1'b1;
    arm(TRIG_DELAY_STOP, TRIG_FROM_TTL, 1'b1);
    check("dstop_acq", acquiring, 32'h1);
    ext_ttl_trigger = 1'b0;
    step(3);
    pulse(0, 4);
    pulse(1, 10);
    check("dstop_post", acquiring, 32'h1);
    pulse(0, 4);
    check("dstop_last", window_open, 32'h1);
    check("dstop_done", acquiring, 32'h0);
    pulse(1, 10);
    arm(TRIG_STOP, TRIG_FROM_ANALOG, 1'b1);
    check("stop_acq", acquiring, 32'h1);
    analog_trigger_inputs = 16'h7FFF;
    step(3);
    check("stop_done", acquiring, 32'h0);
    cfg.pause = 1'b1;
    arm(TRIG_NONE, TRIG_FROM_TTL, 1'b0);
    pulse(0, 4);
    check("paused", window_open, 32'h0);
    cfg.pause = 1'b0;
    pulse(0, 4);
    check("resumed", window_open, 32'h1);
    pulse(1, 10);
    // Internal dividers: 12500 clocks carry 10000 time base ticks
    // Launch at 250 kHz, sample at 500 kHz: launch no faster than sample
    cfg.launch_src = LAUNCH_INTERNAL;
    cfg.sample_src = SAMPLE_INTERNAL;
    cfg.launch_div = 32'd400;
    cfg.sample_div = 32'd200;
    cfg.iter_count = 16'hFFFF;
    arm(TRIG_NONE, TRIG_FROM_TTL, 1'b0);
    lc = launch_count;
    starts = 0;
    step(12500);
    lc = launch_count - lc;
    check("launch_rate", lc >= 24 && lc <= 26, 32'h1);
    check("sample_rate", starts >= 46 && starts <= 50, 32'h1);
    run = 1'b0;
    step(3);
    end_of_test();
  end
endmodule : ai_pacer_trigger_control_tb_top
